// >>> rtl/vip_pkg.sv
// Function
// - each prioritised source has a 3-bit level 0-7; pll lock at 30:28 of group a
// - group a: timer two 18:16, timer one 14:12, timer zero 10:8
// - group a: converter 26:24, flash controller 22:20, software source 6:4
// - source zero has no level; group a bits 3:0 and 31,27,..,7 reserved
// - group b: supply monitor 30:28, comparator 26:24, external input zero 22:20
// - group b: two-wire a slave 6:4, master 2:0; bits 31,27,..,3 reserved
// - nesting control bit 0 enables irq nesting and prioritisation
// - nesting control bit 1 enables fiq nesting and prioritisation
// - nesting off: requests still delivered, priorities ignored, fiq beats irq
// - irq vector read with nesting on sets status bit of serviced level
// - any set status bit blocks irq requests of that level and lower
// - status write clears at most one bit, only the highest-priority set bit
// - status 0x09 written 0xff becomes 0x08, then zero
// - irq vector: zero 31:23, base 22:7, winning source 6:2, zero 1:0
// - fiq vector read with fiq nesting on sets fiq status bit of level
// - fiq request only where raw signal and enable bits are both set
package vip_pkg;
    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NSRC = 22;
    localparam int LVL_W = 3;
    localparam int IDX_W = 5;
    localparam int NSTAT_W = 8;
    localparam int BASE_W = 16;
    localparam int FIELD_STRIDE = 4;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [31:0] ADDR_VEC_BASE = 32'hffff0014;
    localparam logic [31:0] ADDR_IRQ_VEC = 32'hffff001c;
    localparam logic [31:0] ADDR_PRIO_A = 32'hffff0020;
    localparam logic [31:0] ADDR_PRIO_B = 32'hffff0024;
    localparam logic [31:0] ADDR_PRIO_C = 32'hffff0028;
    localparam logic [31:0] ADDR_NEST_CTRL = 32'hffff0030;
    localparam logic [31:0] ADDR_IRQ_NSTAT = 32'hffff003c;
    localparam logic [31:0] ADDR_FIQ_VEC = 32'hffff011c;
    localparam logic [31:0] ADDR_FIQ_NSTAT = 32'hffff013c;
    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] PRIO_A_MASK = 32'h77777770;
    localparam logic [31:0] PRIO_B_MASK = 32'h77777777;
    localparam logic [31:0] PRIO_C_MASK = 32'h00777777;
    localparam int NEST_IRQ_BIT = 0;
    localparam int NEST_FIQ_BIT = 1;
    localparam int VEC_SRC_LSB = 2;
    localparam int VEC_BASE_LSB = 7;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    typedef struct packed {
        logic hit;
        logic [IDX_W-1:0] idx;
        logic [LVL_W-1:0] lvl;
    } vip_pick_t;
endpackage

// >>> rtl/vip_core.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module vip_core
    import vip_pkg::*;
#(
    parameter int NSRC_P = NSRC
)
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [NSRC_P-1:0] IRQ_SRC,
    input wire logic [NSRC_P-1:0] FIQ_SIG,
    input wire logic [NSRC_P-1:0] FIQ_EN,
    output logic [31:0] RDATA,
    output logic IRQ_REQ,
    output logic FIQ_REQ
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0] prio_a, prio_b, prio_c;
    logic [31:0] next_prio_a, next_prio_b, next_prio_c;
    logic [1:0] nest_ctrl, next_nest_ctrl;
    logic [NSTAT_W-1:0] irq_nstat, next_irq_nstat;
    logic [NSTAT_W-1:0] fiq_nstat, next_fiq_nstat;
    logic [BASE_W-1:0] vec_base, next_vec_base;
    logic [31:0] next_rdata;
    logic next_irq_req, next_fiq_req;
    logic [95:0] prio_all;
    logic [LVL_W-1:0] lvl [NSRC_P];
    logic [NSRC_P-1:0] fiq_act;
    vip_pick_t ip, fp;
    logic wr_en, rd_en;

    assign wr_en = WR && CE;
    assign rd_en = RD && CE;
    assign prio_all = {prio_c, prio_b, prio_a};

    // ---------------------------------------------------------------
    // per-source level
    // ---------------------------------------------------------------
    // source n sits in field n of the three groups; source 0 reads 0
    genvar g;
    generate
        for (g = 0; g < NSRC_P; g++)
        begin : g_lvl
            assign lvl[g] = prio_all[FIELD_STRIDE*g +: LVL_W];
            assign fiq_act[g] = FIQ_SIG[g] && FIQ_EN[g];
        end
    endgenerate

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    function automatic vip_pick_t pick(
        input logic [NSRC_P-1:0] req,
        input logic nest,
        input logic [NSTAT_W-1:0] nstat
    );
        vip_pick_t r;
        logic [LVL_W-1:0] l;
        logic [NSTAT_W-1:0] upto;
        r = '0;
        for (int i = 0; i < NSRC_P; i++)
        begin
            l = lvl[i];
            upto = 8'hff >> (3'h7 - l);
            // a set bit at or above this level in priority blocks it
            if (req[i] && (!nest || (nstat & upto) == '0))
            begin
                // strict less-than keeps the lower index on a tie
                if (!r.hit || (nest && l < r.lvl))
                begin
                    r.hit = 1'b1;
                    r.idx = IDX_W'(i);
                    r.lvl = l;
                end
            end
        end
        return r;
    endfunction

    always_comb
    begin
        ip = pick(IRQ_SRC, nest_ctrl[NEST_IRQ_BIT], irq_nstat);
        fp = pick(fiq_act, nest_ctrl[NEST_FIQ_BIT], fiq_nstat);
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    always_comb
    begin
        logic [NSTAT_W-1:0] clr_i, clr_f, set_i, set_f;
        clr_i = '0;
        clr_f = '0;
        set_i = '0;
        set_f = '0;
        next_prio_a = prio_a;
        next_prio_b = prio_b;
        next_prio_c = prio_c;
        next_nest_ctrl = nest_ctrl;
        next_vec_base = vec_base;
        next_rdata = RST_WORD;
        if (wr_en)
        begin
            case (ADDR)
                ADDR_PRIO_A: next_prio_a = WDATA & PRIO_A_MASK;
                ADDR_PRIO_B: next_prio_b = WDATA & PRIO_B_MASK;
                ADDR_PRIO_C: next_prio_c = WDATA & PRIO_C_MASK;
                ADDR_NEST_CTRL: next_nest_ctrl = WDATA[1:0];
                ADDR_VEC_BASE: next_vec_base = WDATA[BASE_W-1:0];
                // only the lowest set bit may go, and only if written one
                ADDR_IRQ_NSTAT:
                    clr_i = irq_nstat & (~irq_nstat + 8'h01)
                        & WDATA[NSTAT_W-1:0];
                ADDR_FIQ_NSTAT:
                    clr_f = fiq_nstat & (~fiq_nstat + 8'h01)
                        & WDATA[NSTAT_W-1:0];
                default: ;
            endcase
        end
        if (rd_en)
        begin
            case (ADDR)
                ADDR_PRIO_A: next_rdata = prio_a;
                ADDR_PRIO_B: next_rdata = prio_b;
                ADDR_PRIO_C: next_rdata = prio_c;
                ADDR_NEST_CTRL: next_rdata = {30'h0, nest_ctrl};
                ADDR_VEC_BASE: next_rdata = {16'h0, vec_base};
                ADDR_IRQ_NSTAT: next_rdata = {24'h0, irq_nstat};
                ADDR_FIQ_NSTAT: next_rdata = {24'h0, fiq_nstat};
                ADDR_IRQ_VEC:
                begin
                    next_rdata = {9'h0, vec_base, ip.idx, 2'h0};
                    if (nest_ctrl[NEST_IRQ_BIT] && ip.hit)
                        set_i = NSTAT_W'(1) << ip.lvl;
                end
                ADDR_FIQ_VEC:
                begin
                    next_rdata = {9'h0, vec_base, fp.idx, 2'h0};
                    if (nest_ctrl[NEST_FIQ_BIT] && fp.hit)
                        set_f = NSTAT_W'(1) << fp.lvl;
                end
                default: next_rdata = RST_WORD;
            endcase
        end
        // set beats clear should both ever meet
        next_irq_nstat = (irq_nstat & ~clr_i) | set_i;
        next_fiq_nstat = (fiq_nstat & ~clr_f) | set_f;
        next_fiq_req = fp.hit;
        next_irq_req = ip.hit && !fp.hit;
    end

    // reset wins over a low clock enable
    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            prio_a <= RST_WORD;
            prio_b <= RST_WORD;
            prio_c <= RST_WORD;
            nest_ctrl <= '0;
            irq_nstat <= '0;
            fiq_nstat <= '0;
            vec_base <= '0;
            RDATA <= RST_WORD;
            IRQ_REQ <= 1'b0;
            FIQ_REQ <= 1'b0;
        end
        else if (CE)
        begin
            prio_a <= next_prio_a;
            prio_b <= next_prio_b;
            prio_c <= next_prio_c;
            nest_ctrl <= next_nest_ctrl;
            irq_nstat <= next_irq_nstat;
            fiq_nstat <= next_fiq_nstat;
            vec_base <= next_vec_base;
            RDATA <= next_rdata;
            IRQ_REQ <= next_irq_req;
            FIQ_REQ <= next_fiq_req;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [LVL_W-1:0] ip_lvl, fp_lvl;
    logic any_fiq;
    assign ip_lvl = ip.lvl;
    assign fp_lvl = fp.lvl;
    assign any_fiq = |fiq_act;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);

    a_fiq_over_irq: assert property (FIQ_REQ |-> !IRQ_REQ)
        else $error("irq raised beside fiq");
    a_fiq_needs_sig: assert property (
        $past(CE) && FIQ_REQ |-> $past(any_fiq))
        else $error("fiq without raw and enable");
    a_vec_set_bit: assert property (
        rd_en && ADDR == ADDR_IRQ_VEC && nest_ctrl[0] && ip.hit
        |=> irq_nstat[$past(ip_lvl)])
        else $error("vector read did not set status");
    a_fiq_vec_set: assert property (
        rd_en && ADDR == ADDR_FIQ_VEC && nest_ctrl[1] && fp.hit
        |=> fiq_nstat[$past(fp_lvl)])
        else $error("fiq vector read did not set status");
    a_nest_off_keep: assert property (
        rd_en && ADDR == ADDR_IRQ_VEC && !nest_ctrl[0]
        |=> irq_nstat == $past(irq_nstat))
        else $error("status changed with nesting off");
    a_level0_blocks: assert property (
        (nest_ctrl[0] && irq_nstat[0]) [*2] |-> !IRQ_REQ)
        else $error("irq passed a level 0 block");
    a_clear_lowest: assert property (
        wr_en && ADDR == ADDR_IRQ_NSTAT && WDATA[7:0] == 8'hff
        |=> irq_nstat == ($past(irq_nstat) & ($past(irq_nstat) - 8'h01)))
        else $error("status clear not lowest bit only");
    a_clear_example: assert property (
        wr_en && ADDR == ADDR_IRQ_NSTAT && WDATA[7:0] == 8'hff
        && irq_nstat == 8'h09 ##1 wr_en && ADDR == ADDR_IRQ_NSTAT
        && WDATA[7:0] == 8'hff |-> irq_nstat == 8'h08 ##1 irq_nstat == 8'h00)
        else $error("0x09 clear sequence wrong");
    a_vec_layout: assert property (
        rd_en && ADDR == ADDR_IRQ_VEC
        |=> RDATA[31:23] == 9'h0 && RDATA[1:0] == 2'h0
        && RDATA[22:7] == $past(vec_base))
        else $error("irq vector layout wrong");
    a_prio_reserved: assert property (
        rd_en && ADDR == ADDR_PRIO_A |=> RDATA[3:0] == 4'h0 && !RDATA[31])
        else $error("reserved priority bits set");
    a_reset_clear: assert property (
        $past(SRST) |-> prio_a == '0 && nest_ctrl == '0 && irq_nstat == '0)
        else $error("state not cleared by reset");

    // ---------------------------------------------------------------
    // register map checks
    // ---------------------------------------------------------------
    a_prio_b_mask: assert property (
        rd_en && ADDR == ADDR_PRIO_B |=> (RDATA & ~PRIO_B_MASK) == '0)
        else $error("reserved group b bits set");
    a_prio_c_mask: assert property (
        rd_en && ADDR == ADDR_PRIO_C |=> (RDATA & ~PRIO_C_MASK) == '0)
        else $error("reserved group c bits set");
    a_ctrl_bits: assert property (
        rd_en && ADDR == ADDR_NEST_CTRL |=> RDATA[31:2] == 30'h0)
        else $error("nesting control reads high bits");
    a_rdata_idle: assert property (
        !RD && CE |=> RDATA == '0)
        else $error("read data without a read");
    a_vec_index: assert property (
        rd_en && ADDR == ADDR_IRQ_VEC |=> RDATA[6:2] < IDX_W'(NSRC_P))
        else $error("vector index out of range");
    a_fiq_vec_layout: assert property (
        rd_en && ADDR == ADDR_FIQ_VEC
        |=> RDATA[31:23] == 9'h0 && RDATA[1:0] == 2'h0
        && RDATA[22:7] == $past(vec_base))
        else $error("fiq vector layout wrong");
    a_fiq_clear: assert property (
        wr_en && ADDR == ADDR_FIQ_NSTAT && WDATA[7:0] == 8'hff
        |=> fiq_nstat == ($past(fiq_nstat) & ($past(fiq_nstat) - 8'h01)))
        else $error("fiq status clear not lowest bit only");
    a_fiq_off_keep: assert property (
        rd_en && ADDR == ADDR_FIQ_VEC && !nest_ctrl[1]
        |=> fiq_nstat == $past(fiq_nstat))
        else $error("fiq status changed with nesting off");
    a_nstat_hold: assert property (
        !(wr_en && ADDR == ADDR_IRQ_NSTAT) && !(rd_en && ADDR == ADDR_IRQ_VEC)
        |=> irq_nstat == $past(irq_nstat))
        else $error("irq status moved on its own");
    a_src0_level: assert property (
        lvl[0] == 3'h0)
        else $error("source zero has a level");
    a_irq_needs_src: assert property (
        $past(CE) && IRQ_REQ |-> $past(|IRQ_SRC))
        else $error("irq without a pending source");
    a_reset_outputs: assert property (
        $past(SRST) |-> !IRQ_REQ && !FIQ_REQ && RDATA == '0)
        else $error("outputs not cleared by reset");

    // ---------------------------------------------------------------
    // coverage
    // ---------------------------------------------------------------
    c_nested_two: cover property (irq_nstat[0] && irq_nstat[3]);
    c_fiq_vec_read: cover property (rd_en && ADDR == ADDR_FIQ_VEC && fp.hit);
    c_status_clear: cover property (
        wr_en && ADDR == ADDR_IRQ_NSTAT && irq_nstat != '0);
    c_vec_read: cover property (rd_en && ADDR == ADDR_IRQ_VEC && ip.hit);
    c_both_pending: cover property (ip.hit && fp.hit ##1 FIQ_REQ);
endmodule

// >>> tb/vip_core_model.sv
`timescale 1ns/10ps
module vip_core_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic irq_req,
    input wire logic fiq_req,
    output logic [7:0] fiq_entries
);
    // -----------------------------------------------------------
    // core entry counter
    // -----------------------------------------------------------
    logic fiq_prev;
    logic next_fiq_prev;
    logic [7:0] next_fiq_entries;
    // only rising requests count: a held level is one entry
    always_comb
    begin
        next_fiq_prev = fiq_req;
        next_fiq_entries = fiq_entries;
        if (fiq_req && !fiq_prev)
            next_fiq_entries = fiq_entries + 8'h01;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fiq_prev <= 1'b0;
            fiq_entries <= 8'h00;
        end
        else
        begin
            fiq_prev <= next_fiq_prev;
            fiq_entries <= next_fiq_entries;
        end
    end
endmodule

// >>> tb/test_vectored_irq_priority_nesting.sv
`timescale 1ns/10ps
module test_vectored_irq_priority_nesting
    import vip_pkg::*;
;
    // -----------------------------------------------------------
    // stimulus and design
    // -----------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] base;
    logic [31:0] rnd;
    logic [31:0] rdata;
    logic irq_req;
    logic fiq_req;
    logic [NSRC-1:0] irq_src = '0;
    logic [NSRC-1:0] fiq_sig = '0;
    logic [NSRC-1:0] fiq_en = '0;
    logic [7:0] fiq_entries;
    logic [31:0] exp_q[$];
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    vip_core vip_core_i (.CORE_CLK(clk), .SRST(srst), .CE(1'b1),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .IRQ_SRC(irq_src),
        .FIQ_SIG(fiq_sig), .FIQ_EN(fiq_en), .RDATA(rdata),
        .IRQ_REQ(irq_req), .FIQ_REQ(fiq_req));
    vip_core_model vip_core_model_i (.clk(clk), .srst(srst),
        .irq_req(irq_req), .fiq_req(fiq_req), .fiq_entries(fiq_entries));

    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(exp);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task vec(input logic [4:0] idx);
        rd_reg(ADDR_IRQ_VEC, {9'h000, base[15:0], idx, 2'b00});
    endtask

    task src(input logic [NSRC-1:0] i, input logic [NSRC-1:0] f,
        input logic [NSRC-1:0] e);
        @(posedge clk);
        irq_src <= i;
        fiq_sig <= f;
        fiq_en <= e;
    endtask

    // two edges: requests register on the first, the second is spare
    task settle(input logic ir, input logic fr);
        repeat (2) @(posedge clk);
        #1;
        check("irq_req", {31'h0, irq_req}, {31'h0, ir});
        check("fiq_req", {31'h0, fiq_req}, {31'h0, fr});
    endtask

    // -----------------------------------------------------------
    // read data scoreboard and watchdog
    // -----------------------------------------------------------
    always @(posedge clk)
    begin
        rd_q <= rd;
        if (rd_q)
        begin
            if (exp_q.size() == 0)
                check("rdata note", 32'h1, 32'h0);
            else
                check("rdata", rdata, exp_q.pop_front());
        end
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            print_verdict;
        end
    end

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial
    begin
        void'($urandom(67961));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd_reg(ADDR_PRIO_A, 32'h0);
        rd_reg(ADDR_PRIO_B, 32'h0);
        rd_reg(ADDR_PRIO_C, 32'h0);
        rd_reg(ADDR_NEST_CTRL, 32'h0);
        rd_reg(ADDR_IRQ_NSTAT, 32'h0);
        rd_reg(32'hffff0040, 32'h0);
        rnd = $urandom;
        base = {16'h0000, rnd[31:16]};
        wr_reg(ADDR_PRIO_A, 32'hffffffff);
        wr_reg(ADDR_PRIO_B, rnd);
        wr_reg(ADDR_PRIO_C, 32'hffffffff);
        wr_reg(ADDR_VEC_BASE, base);
        rd_reg(ADDR_PRIO_A, 32'h77777770);
        rd_reg(ADDR_PRIO_B, rnd & 32'h77777777);
        rd_reg(ADDR_PRIO_C, 32'h00777777);
        wr_reg(ADDR_PRIO_A, 32'h00035000);
        src(22'h000018, 22'h0, 22'h0);
        settle(1'b1, 1'b0);
        vec(5'd3);
        rd_reg(ADDR_IRQ_NSTAT, 32'h0);
        wr_reg(ADDR_NEST_CTRL, 32'h1);
        vec(5'd4);
        rd_reg(ADDR_IRQ_NSTAT, 32'h08);
        settle(1'b0, 1'b0);
        src(22'h000019, 22'h0, 22'h0);
        settle(1'b1, 1'b0);
        vec(5'd0);
        rd_reg(ADDR_IRQ_NSTAT, 32'h09);
        wr_reg(ADDR_IRQ_NSTAT, 32'hff);
        rd_reg(ADDR_IRQ_NSTAT, 32'h08);
        wr_reg(ADDR_IRQ_NSTAT, 32'hff);
        rd_reg(ADDR_IRQ_NSTAT, 32'h0);
        src(22'h000019, 22'h000020, 22'h0);
        settle(1'b1, 1'b0);
        src(22'h000019, 22'h000020, 22'h000020);
        settle(1'b0, 1'b1);
        wr_reg(ADDR_NEST_CTRL, 32'h3);
        rd_reg(ADDR_NEST_CTRL, 32'h3);
        src(22'h000018, 22'h0, 22'h0);
        wr_reg(ADDR_PRIO_A, 32'h00011000);
        vec(5'd3);
        rd_reg(ADDR_IRQ_NSTAT, 32'h02);
        src(22'h0, 22'h000020, 22'h000020);
        settle(1'b0, 1'b1);
        rd_reg(ADDR_FIQ_VEC, {9'h000, base[15:0], 5'd5, 2'b00});
        rd_reg(ADDR_FIQ_NSTAT, 32'h01);
        settle(1'b0, 1'b0);
        wr_reg(ADDR_FIQ_NSTAT, 32'hff);
        rd_reg(ADDR_FIQ_NSTAT, 32'h0);
        repeat (3) @(posedge clk);
        check("fiq entries", {24'h0, fiq_entries}, 32'h3);
        print_verdict;
    end
endmodule
